// ==== verilog/dbg_cmp_pkg.sv ====
// Constants, field layouts and carrier types of the debug bus comparator block.
// Assumes one system bus clock and a monitored CPU bus with 16-bit address and data.
// How it works
// [R01] Comparators A and C pick match on data equal or data different.
// [R02] B/D with size compare off: word and byte accesses of target match.
// [R03] B/D with size compare on: select 0 matches words, 1 matches bytes.
// [R04] B/D set for byte accesses ignore a word access covering the target.
// [R05] Only exact address equality matches; a word at target minus one does not.
// [R06] Software loads the exact address that the watched code issues.
// [R07] Equality mode: masked-in data bits must all equal the comparator data.
// [R08] Equality mode with mask all clear: address alone decides.
// [R09] Difference mode: any masked-in differing data bit gives a match.
// [R10] Difference mode with mask all clear never matches.
// [R11] A/C data compare ignores access size; masked bits are don't-care.
// [R12] Each qualifying access gives a one-cycle match pulse.
package dbg_cmp_pkg;

    localparam int NUM_CMP = 4;
    localparam int MON_ADDR_W = 16;
    localparam int MON_DATA_W = 16;
    localparam int BUS_AW = 5;
    localparam int BUS_DW = 32;

    // Word offsets inside one comparator's group of four registers
    localparam logic [1:0] SUB_CTRL = 2'h0;
    localparam logic [1:0] SUB_ADDR = 2'h1;
    localparam logic [1:0] SUB_DATA = 2'h2;
    localparam logic [1:0] SUB_MASK = 2'h3;

    // Word offsets of the shared registers
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h11;

    // Control register field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_MISMATCH = 1;
    localparam int CTRL_SIZE_EN = 2;
    localparam int CTRL_SIZE_SEL = 3;

    // Mask register: low byte mask, then high byte mask
    localparam int MASK_LO = 0;
    localparam int MASK_HI = 8;

    // Access size encoding, as the size select bit holds it
    localparam logic SIZE_WORD = 1'b0;
    localparam logic SIZE_BYTE = 1'b1;

    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    typedef struct packed {
        logic valid;
        logic is_byte;
        logic [MON_ADDR_W-1:0] addr;
        logic [MON_DATA_W-1:0] data;
    } bus_access_t;

    typedef struct packed {
        logic enable;
        logic data_mismatch_select;
        logic size_compare_enable;
        logic size_select;
        logic [MON_ADDR_W-1:0] addr;
        logic [MON_DATA_W-1:0] data;
        logic [7:0] data_mask_high_byte;
        logic [7:0] data_mask_low_byte;
    } cmp_cfg_t;

    localparam cmp_cfg_t CFG_RESET = '0;

    // Even comparators (A, C) compare data; odd ones (B, D) compare size
    function automatic logic has_data_cmp(input int idx);
        return (idx % 2) == 0;
    endfunction

endpackage

// ==== verilog/bus_comparator_match.sv ====
// Match qualification of the four debug bus comparators, with Avalon-MM registers.
// Assumes the monitored access arrives as one valid cycle per CPU bus access,
// synchronous to mclk, and an Avalon master that holds requests under waitrequest.
`timescale 1ns/1ps

module bus_comparator_match (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Avalon-MM register slave, word addressed
    input wire logic [dbg_cmp_pkg::BUS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [dbg_cmp_pkg::BUS_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [dbg_cmp_pkg::BUS_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Monitored CPU bus access
    input dbg_cmp_pkg::bus_access_t mon_acc,
    // Match pulses and interrupt
    output logic [dbg_cmp_pkg::NUM_CMP-1:0] cmp_match,
    output logic irq
);

    dbg_cmp_pkg::cmp_cfg_t cfg_r [dbg_cmp_pkg::NUM_CMP];
    logic [dbg_cmp_pkg::NUM_CMP-1:0] match_r;
    logic [dbg_cmp_pkg::NUM_CMP-1:0] hit_nxt;
    logic [dbg_cmp_pkg::NUM_CMP-1:0] status_r;
    logic [dbg_cmp_pkg::NUM_CMP-1:0] irq_mask_r;
    logic [dbg_cmp_pkg::NUM_CMP-1:0] status_clr;
    logic [dbg_cmp_pkg::BUS_DW-1:0] readdata_r;
    logic [dbg_cmp_pkg::BUS_DW-1:0] rd_word;
    logic [dbg_cmp_pkg::BUS_DW-1:0] wr_word;
    logic ack_r;
    logic wr_go;
    logic [1:0] cmp_sel;
    logic [1:0] sub_sel;
    logic in_cmp;

    // Byte-lane mask from the Avalon byte enables
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Masked data bits that differ from the comparator value
    function automatic logic [15:0] data_diff(input dbg_cmp_pkg::cmp_cfg_t c,
                                              input logic [15:0] d);
        return (d ^ c.data) & {c.data_mask_high_byte, c.data_mask_low_byte};
    endfunction

    // Data qualification of A and C; size plays no part here
    function automatic logic data_ok(input dbg_cmp_pkg::cmp_cfg_t c, input logic [15:0] d);
        logic [15:0] diff;
        diff = data_diff(c, d);
        if (c.data_mismatch_select) begin // [R01]
            return |diff; // [R09] [R10]
        end
        return diff == 16'h0000; // [R07] [R08] [R11]
    endfunction

    // Size qualification of B and D
    function automatic logic size_ok(input dbg_cmp_pkg::cmp_cfg_t c, input logic is_byte);
        if (!c.size_compare_enable) begin
            return 1'b1; // [R02]
        end
        return is_byte == c.size_select; // [R03] [R04]
    endfunction

    // Register decode
    assign in_cmp = !avs_address[4];
    assign cmp_sel = avs_address[3:2];
    assign sub_sel = avs_address[1:0];

    // One wait cycle per access: address decode and read data settle before the answer
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign wr_go = avs_write && ack_r;
    assign avs_readdata = readdata_r;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    // Read mux; unmapped words and absent fields read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (in_cmp) begin
            case (sub_sel)
                dbg_cmp_pkg::SUB_CTRL: begin
                    rd_word[dbg_cmp_pkg::CTRL_EN] = cfg_r[cmp_sel].enable;
                    rd_word[dbg_cmp_pkg::CTRL_MISMATCH] = cfg_r[cmp_sel].data_mismatch_select;
                    rd_word[dbg_cmp_pkg::CTRL_SIZE_EN] = cfg_r[cmp_sel].size_compare_enable;
                    rd_word[dbg_cmp_pkg::CTRL_SIZE_SEL] = cfg_r[cmp_sel].size_select;
                end
                dbg_cmp_pkg::SUB_ADDR: rd_word[15:0] = cfg_r[cmp_sel].addr;
                dbg_cmp_pkg::SUB_DATA: rd_word[15:0] = cfg_r[cmp_sel].data;
                dbg_cmp_pkg::SUB_MASK: begin
                    rd_word[dbg_cmp_pkg::MASK_LO +: 8] = cfg_r[cmp_sel].data_mask_low_byte;
                    rd_word[dbg_cmp_pkg::MASK_HI +: 8] = cfg_r[cmp_sel].data_mask_high_byte;
                end
                default: rd_word = 32'h0000_0000;
            endcase
        end else if (avs_address == dbg_cmp_pkg::OFS_STATUS) begin
            rd_word[3:0] = status_r;
        end else if (avs_address == dbg_cmp_pkg::OFS_IRQ_MASK) begin
            rd_word[3:0] = irq_mask_r;
        end
    end

    // Read data is captured in the wait cycle and stands in the answer cycle
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            readdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            readdata_r <= rd_word;
        end
    end

    // Byte-enabled write merges into the current word
    assign wr_word = (rd_word & ~lane_mask(avs_byteenable))
                   | (avs_writedata & lane_mask(avs_byteenable));

    // Comparator configuration; fields a comparator lacks stay zero
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int i = 0; i < dbg_cmp_pkg::NUM_CMP; i++) begin
                cfg_r[i] <= dbg_cmp_pkg::CFG_RESET;
            end
        end else if (wr_go && in_cmp) begin
            case (sub_sel)
                dbg_cmp_pkg::SUB_CTRL: begin
                    cfg_r[cmp_sel].enable <= wr_word[dbg_cmp_pkg::CTRL_EN];
                    if (dbg_cmp_pkg::has_data_cmp(int'(cmp_sel))) begin
                        cfg_r[cmp_sel].data_mismatch_select <=
                            wr_word[dbg_cmp_pkg::CTRL_MISMATCH];
                    end else begin
                        cfg_r[cmp_sel].size_compare_enable <= wr_word[dbg_cmp_pkg::CTRL_SIZE_EN];
                        cfg_r[cmp_sel].size_select <= wr_word[dbg_cmp_pkg::CTRL_SIZE_SEL];
                    end
                end
                dbg_cmp_pkg::SUB_ADDR: cfg_r[cmp_sel].addr <= wr_word[15:0];
                dbg_cmp_pkg::SUB_DATA: begin
                    if (dbg_cmp_pkg::has_data_cmp(int'(cmp_sel))) begin
                        cfg_r[cmp_sel].data <= wr_word[15:0];
                    end
                end
                dbg_cmp_pkg::SUB_MASK: begin
                    if (dbg_cmp_pkg::has_data_cmp(int'(cmp_sel))) begin
                        cfg_r[cmp_sel].data_mask_low_byte <= wr_word[dbg_cmp_pkg::MASK_LO +: 8];
                        cfg_r[cmp_sel].data_mask_high_byte <= wr_word[dbg_cmp_pkg::MASK_HI +: 8];
                    end
                end
                default: ;
            endcase
        end
    end

    // Qualification of the current access; software must load the exact address [R06]
    always_comb begin
        for (int i = 0; i < dbg_cmp_pkg::NUM_CMP; i++) begin
            hit_nxt[i] = mon_acc.valid && cfg_r[i].enable
                       && (mon_acc.addr == cfg_r[i].addr); // [R05]
            if (dbg_cmp_pkg::has_data_cmp(i)) begin
                hit_nxt[i] = hit_nxt[i] && data_ok(cfg_r[i], mon_acc.data);
            end else begin
                hit_nxt[i] = hit_nxt[i] && size_ok(cfg_r[i], mon_acc.is_byte);
            end
        end
    end

    // One registered pulse per qualifying access
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            match_r <= '0;
        end else begin
            match_r <= hit_nxt; // [R12]
        end
    end

    assign cmp_match = match_r;

    // Write-one-to-clear; a match in the clearing cycle wins so no event is lost
    assign status_clr = (wr_go && avs_address == dbg_cmp_pkg::OFS_STATUS && avs_byteenable[0])
                      ? avs_writedata[3:0] : 4'h0;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            status_r <= dbg_cmp_pkg::STATUS_RESET;
        end else begin
            status_r <= (status_r & ~status_clr) | hit_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_mask_r <= dbg_cmp_pkg::IRQ_MASK_RESET;
        end else if (wr_go && avs_address == dbg_cmp_pkg::OFS_IRQ_MASK && avs_byteenable[0]) begin
            irq_mask_r <= avs_writedata[3:0];
        end
    end

    // Level interrupt straight from flops
    assign irq = |(status_r & irq_mask_r);

    // Helpers read only by the checks below
    logic [15:0] diff_a;
    logic [15:0] mask_a;
    assign diff_a = data_diff(cfg_r[0], mon_acc.data);
    assign mask_a = {cfg_r[0].data_mask_high_byte, cfg_r[0].data_mask_low_byte};

    sequence s_hit_a;
        mon_acc.valid && cfg_r[0].enable && mon_acc.addr == cfg_r[0].addr;
    endsequence

    sequence s_hit_b;
        mon_acc.valid && cfg_r[1].enable && mon_acc.addr == cfg_r[1].addr;
    endsequence

    property p_sense_select;
        @(posedge mclk) disable iff (!rst_b)
        (s_hit_a ##0 (diff_a == 16'h0000 && mask_a != 16'h0000))
        |=> (match_r[0] == !$past(cfg_r[0].data_mismatch_select));
    endproperty
    a_sense_select: assert property (p_sense_select) else $error("sense select wrong"); // [R01]

    property p_size_off;
        @(posedge mclk) disable iff (!rst_b)
        (s_hit_b ##0 !cfg_r[1].size_compare_enable) |=> match_r[1];
    endproperty
    a_size_off: assert property (p_size_off) else $error("size-off access missed"); // [R02]

    property p_size_on;
        @(posedge mclk) disable iff (!rst_b)
        (s_hit_b ##0 cfg_r[1].size_compare_enable)
        |=> (match_r[1] == ($past(mon_acc.is_byte) == $past(cfg_r[1].size_select)));
    endproperty
    a_size_on: assert property (p_size_on) else $error("size compare wrong"); // [R03]

    property p_byte_rejects_word;
        @(posedge mclk) disable iff (!rst_b)
        (cfg_r[1].size_compare_enable && cfg_r[1].size_select == dbg_cmp_pkg::SIZE_BYTE
         && mon_acc.is_byte == dbg_cmp_pkg::SIZE_WORD) |=> !match_r[1];
    endproperty
    a_byte_rejects_word: assert property (p_byte_rejects_word)
        else $error("word access matched byte comparator"); // [R04]

    property p_exact_addr;
        @(posedge mclk) disable iff (!rst_b)
        (16'(mon_acc.addr + 16'h0001) == cfg_r[0].addr) |=> !match_r[0];
    endproperty
    a_exact_addr: assert property (p_exact_addr) else $error("adjacent address matched"); // [R05]

    property p_eq_masked;
        @(posedge mclk) disable iff (!rst_b)
        (!cfg_r[0].data_mismatch_select && diff_a != 16'h0000) |=> !match_r[0];
    endproperty
    a_eq_masked: assert property (p_eq_masked) else $error("equal mode matched on diff"); // [R07]

    property p_eq_nomask;
        @(posedge mclk) disable iff (!rst_b)
        (s_hit_a ##0 (!cfg_r[0].data_mismatch_select && mask_a == 16'h0000)) |=> match_r[0];
    endproperty
    a_eq_nomask: assert property (p_eq_nomask) else $error("address-only match missed"); // [R08]

    property p_diff_match;
        @(posedge mclk) disable iff (!rst_b)
        (s_hit_a ##0 (cfg_r[0].data_mismatch_select && diff_a != 16'h0000)) |=> match_r[0];
    endproperty
    a_diff_match: assert property (p_diff_match) else $error("difference missed"); // [R09]

    property p_diff_nomask;
        @(posedge mclk) disable iff (!rst_b)
        (cfg_r[0].data_mismatch_select && mask_a == 16'h0000) |=> !match_r[0];
    endproperty
    a_diff_nomask: assert property (p_diff_nomask) else $error("diff mode unmasked match"); // [R10]

    property p_byte_data;
        @(posedge mclk) disable iff (!rst_b)
        (s_hit_a ##0 (mon_acc.is_byte && !cfg_r[0].data_mismatch_select && diff_a == 16'h0000))
        |=> match_r[0];
    endproperty
    a_byte_data: assert property (p_byte_data) else $error("byte access data match missed"); // [R11]

    property p_pulse_status;
        @(posedge mclk) disable iff (!rst_b)
        !mon_acc.valid |=> (match_r == '0);
    endproperty
    a_pulse_status: assert property (p_pulse_status) else $error("stray match pulse"); // [R12]

    // Every pulse leaves its sticky bit set, even when a clear lands in that cycle
    property p_status_sticky;
        @(posedge mclk) disable iff (!rst_b)
        (match_r & ~status_r) == '0;
    endproperty
    a_status_sticky: assert property (p_status_sticky) else $error("match without status"); // [R12]

endmodule

// ==== sim/cpu_bus_model.sv ====
// Behavioural CPU bus that issues the accesses the comparators watch.
// Assumes callers sit just after a rising mclk edge.
`timescale 1ns/1ps

module cpu_bus_model (
    // Clock
    input wire logic mclk,
    // Monitored access
    output dbg_cmp_pkg::bus_access_t mon_acc
);
    initial begin
        mon_acc = '0;
    end

    // Drives the access for one cycle and leaves valid set until idle; calls may follow back to back
    task automatic issue(input logic [15:0] a, input logic [15:0] d, input logic b);
        mon_acc <= {1'b1, b, a, d};
        @(posedge mclk);
    endtask

    // Idle shows the inverse of the last access so stale values never look live
    task automatic idle();
        mon_acc <= {1'b0, ~mon_acc.is_byte, ~mon_acc.addr, ~mon_acc.data};
    endtask
endmodule

// ==== sim/bus_comparator_match_tb.sv ====
// Self-checking bench for the comparator match block.
// Assumes the bus model above and the package constants of the design.
`timescale 1ns/1ps

module bus_comparator_match_tb;
    logic mclk;
    logic rst_b;
    logic [dbg_cmp_pkg::BUS_AW-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [dbg_cmp_pkg::BUS_DW-1:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [dbg_cmp_pkg::BUS_DW-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] cmp_match;
    logic irq;
    dbg_cmp_pkg::bus_access_t mon_acc;
    int err_total = 0;
    int checks = 0;
    int seed = 32'he2a344af;
    logic [3:0] exp_q[$];
    logic acc_d = 1'b0;
    logic [3:0] c_ctrl[4];
    logic [15:0] c_addr[4];
    logic [15:0] c_data[4];
    logic [15:0] c_mask[4];
    logic [3:0] exp_status;
    logic [3:0] irq_en;
    logic [31:0] rd;

    // 50 MHz clock
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    bus_comparator_match bus_comparator_match_inst (
        .mclk(mclk),
        .rst_b(rst_b),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .mon_acc(mon_acc),
        .cmp_match(cmp_match),
        .irq(irq)
    );

    cpu_bus_model cpu_bus_model_inst (
        .mclk(mclk),
        .mon_acc(mon_acc)
    );

    // Compare tasks, one per kind of result
    task automatic chk4(input logic [3:0] e, input logic [3:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: match exp %h got %h", $time, e, g);
        end
    endtask

    task automatic chk32(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: read exp %h got %h", $time, e, g);
        end
    endtask

    task automatic chk1(input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: irq exp %b got %b", $time, e, g);
        end
    endtask

    // One Avalon transfer; held until waitrequest is seen low, bounded wait
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            err_total++;
            $display("Error at %0t: bus hang", $time);
        end
    endtask

    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk32(e, rd);
    endtask

    // Reference model of one access against the mirrored setup
    function automatic logic [3:0] exp_match(input logic [15:0] a, d, input logic b);
        logic [3:0] r;
        logic [15:0] df;
        logic hit;
        for (int k = 0; k < 4; k++) begin
            df = (d ^ c_data[k]) & c_mask[k];
            hit = c_ctrl[k][0] && a == c_addr[k];
            if (k % 2 == 0)
                r[k] = hit && (c_ctrl[k][1] ? df != 0 : df == 0);
            else
                r[k] = hit && (!c_ctrl[k][2] || b == c_ctrl[k][3]);
        end
        return r;
    endfunction

    // Setup of one comparator; fields it lacks read back as zero
    task automatic cfg(input int k, input logic [3:0] ctl, input logic [15:0] a, d, m);
        c_ctrl[k] = (k % 2 == 0) ? (ctl & 4'h3) : (ctl & 4'hD);
        c_addr[k] = a;
        c_data[k] = (k % 2 == 0) ? d : 16'h0;
        c_mask[k] = (k % 2 == 0) ? m : 16'h0;
        bus(1'b1, 5'(4 * k), {28'h0, ctl});
        bus(1'b1, 5'(4 * k + 1), {16'h0, a});
        bus(1'b1, 5'(4 * k + 2), {16'h0, d});
        bus(1'b1, 5'(4 * k + 3), {16'h0, m});
        rchk(5'(4 * k), {28'h0, c_ctrl[k]});
        rchk(5'(4 * k + 3), {16'h0, c_mask[k]});
    endtask

    task automatic acc(input logic [15:0] a, d, input logic b);
        exp_q.push_back(exp_match(a, d, b));
        exp_status |= exp_match(a, d, b);
        cpu_bus_model_inst.issue(a, d, b);
    endtask

    // Watcher: a result is due the cycle after each valid access, else no pulse
    always @(posedge mclk) begin
        if (rst_b === 1'b1 && acc_d && exp_q.size() > 0)
            chk4(exp_q.pop_front(), cmp_match);
        else if (rst_b === 1'b1)
            chk4(4'h0, cmp_match);
        acc_d <= mon_acc.valid;
    end

    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog: the sequence needs about a thousand cycles, this allows 40000
    initial begin
        #(20 * 40000);
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end

    // Main sequence: eight setups cover every sense, mask and size mode
    initial begin
        logic [15:0] tgt;
        logic [15:0] pick;
        logic [31:0] r;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        rst_b = 1'b0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        for (int a = 0; a < 32; a++)
            rchk(5'(a), 32'h0);
        bus(1'b1, 5'h1F, 32'hFFFFFFFF);
        rchk(5'h1F, 32'h0);
        for (int m = 0; m < 8; m++) begin
            tgt = 16'($random(seed));
            irq_en = 4'($random(seed));
            for (int k = 0; k < 4; k++)
                cfg(k, {m[2], m[1], m[0], m != 0}, tgt, 16'($random(seed)),
                    m[1] ? 16'($random(seed)) : 16'h0);
            bus(1'b1, dbg_cmp_pkg::OFS_IRQ_MASK, {28'h0, irq_en});
            bus(1'b1, dbg_cmp_pkg::OFS_STATUS, 32'hF);
            exp_status = 4'h0;
            // Targets, neighbours below and above, back to back, mixed sizes
            for (int i = 0; i < 16; i++) begin
                r = $random(seed);
                pick = r[1:0] == 0 ? c_data[0] : r[1:0] == 1 ? c_data[2] : r[31:16];
                acc(r[3:2] == 0 ? tgt - 16'h1 : r[3:2] == 1 ? tgt + 16'h1 : tgt, pick, r[4]);
            end
            cpu_bus_model_inst.idle();
            repeat (2) @(posedge mclk);
            rchk(dbg_cmp_pkg::OFS_STATUS, {28'h0, exp_status});
            chk1(|(exp_status & irq_en), irq);
            // Partial write-one-to-clear leaves the other sticky bits
            bus(1'b1, dbg_cmp_pkg::OFS_STATUS, 32'h5);
            exp_status &= 4'hA;
            rchk(dbg_cmp_pkg::OFS_STATUS, {28'h0, exp_status});
            chk1(|(exp_status & irq_en), irq);
        end
        // Lane-limited writes: only enabled byte lanes change, lane 0 gates the clear
        avs_byteenable <= 4'h2;
        bus(1'b1, 5'h01, 32'h0000_5A00);
        c_addr[0][15:8] = 8'h5A;
        rchk(5'h01, {16'h0, c_addr[0]});
        avs_byteenable <= 4'hE;
        bus(1'b1, dbg_cmp_pkg::OFS_STATUS, 32'hF);
        rchk(dbg_cmp_pkg::OFS_STATUS, {28'h0, exp_status});
        avs_byteenable <= 4'hF;
        stop_test();
    end
endmodule
